// [bench/pulse_source.sv]
// Stand-in for the pulse signal arriving on the channel's timer input
`timescale 1ns/1ns
module pulse_source
(
  // Clock
  input wire logic ref_clk,
  // Measured signal
  output logic pin
);
  initial pin = 1'b1;

  // Level moves just after an edge and then holds, so every tick in between sees it
  task automatic drive(input logic level, input int hold);
    @(posedge ref_clk);
    pin <= level;
    repeat (hold - 1) @(posedge ref_clk);
  endtask
endmodule

// [bench/test_pulse_interval_capture.sv]
// Self-checking bench for the pulse interval capture channel
`timescale 1ns/1ns
module test_pulse_interval_capture;
  localparam int LOG0 = 0;
  localparam int LOG1 = 1;
  localparam int LOG2 = 2;
  localparam int LOG3 = 3;
  localparam int LIMIT = 20000;
  logic ref_clk;
  logic rstn;
  pulse_interval_pkg::bus_req_t bus_req;
  logic [31:0] rd_data;
  logic timer_input_pin;
  logic timer_output_pin;
  logic channel_interrupt;
  logic channel_enabled_status;
  int err_total;
  int checks;
  int irq_seen;
  int cycles;

  pulse_interval_capture #(.PRE0_LOG(LOG0), .PRE1_LOG(LOG1), .PRE2_LOG(LOG2), .PRE3_LOG(LOG3))
    DUT (.ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req), .rd_data(rd_data),
    .timer_input_pin(timer_input_pin), .timer_output_pin(timer_output_pin),
    .channel_interrupt(channel_interrupt), .channel_enabled_status(channel_enabled_status));
  pulse_source partner (.ref_clk(ref_clk), .pin(timer_input_pin));

  // ************************************************************
  // Clock, watchdog and shared tasks
  // ************************************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cycles++;
    if (channel_interrupt === 1'b1)
      irq_seen++;
    if (cycles == LIMIT)
    begin
      err_total++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge ref_clk);
    bus_req.addr <= addr;
    bus_req.wdata <= data;
    bus_req.wr <= 1'b1;
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] addr, output logic [31:0] data);
    @(posedge ref_clk);
    bus_req.addr <= addr;
    bus_req.rd <= 1'b1;
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1;
    data = rd_data;
  endtask

  task automatic reg_chk(input string what, input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] v;
    reg_rd(addr, v);
    chk(what, exp, v);
  endtask

  function automatic logic [31:0] mode_word(input logic [1:0] csel, input logic [1:0] cos,
    input logic irq0, input logic [3:0] fn, input logic [2:0] trg);
    mode_word = {16'h0000, csel, 2'h0, 1'h0, trg, cos, 1'h0, fn, irq0};
  endfunction

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    logic [7:0] ofs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h24, 8'h30};
    foreach (ofs[i])
      reg_chk("reset value", ofs[i], 32'h0000_0000);
    chk("enabled at reset", 32'h0, {31'h0, channel_enabled_status});
  endtask

  // Each prescaler paired with one edge mode; edge spacing scales with the ratio
  task automatic t_edges();
    int r;
    int exp_cap;
    int exp_irq;
    for (int i = 0; i < 4; i++)
    begin
      r = 1 << (i == 0 ? LOG0 : i == 1 ? LOG1 : i == 2 ? LOG2 : LOG3);
      exp_cap = (i < 2) ? 13 : 4;
      exp_irq = (i < 2) ? 2 : 4;
      reg_wr(pulse_interval_pkg::OFS_MODE, mode_word(2'(i), pulse_interval_pkg::COS_KEEP, 1'b0,
        pulse_interval_pkg::FUNC_CAPTURE, pulse_interval_pkg::TRIG_EXT_CAPTURE));
      reg_wr(pulse_interval_pkg::OFS_EDGE, 32'(i));
      reg_wr(pulse_interval_pkg::OFS_REWRITE, 32'h0000_0000);
      irq_seen = 0;
      reg_wr(pulse_interval_pkg::OFS_START, 32'h0000_0001);
      partner.drive(1'b0, 5 * r);
      partner.drive(1'b1, 9 * r);
      partner.drive(1'b0, 5 * r);
      partner.drive(1'b1, 9 * r);
      chk("interrupt pulses", 32'(exp_irq), 32'(irq_seen));
      reg_chk("captured interval", pulse_interval_pkg::OFS_DATA, 32'(exp_cap));
      chk("enabled running", 32'h1, {31'h0, channel_enabled_status});
      reg_wr(pulse_interval_pkg::OFS_STOP, 32'h0000_0001);
    end
  endtask

  task automatic t_stop();
    logic [31:0] a;
    logic [31:0] b;
    reg_wr(pulse_interval_pkg::OFS_MODE, mode_word(2'h0, pulse_interval_pkg::COS_FLAG, 1'b1,
      pulse_interval_pkg::FUNC_CAPTURE, pulse_interval_pkg::TRIG_EXT_CAPTURE));
    reg_wr(pulse_interval_pkg::OFS_EDGE, 32'(pulse_interval_pkg::EDGE_FALL));
    irq_seen = 0;
    reg_wr(pulse_interval_pkg::OFS_START, 32'h0000_0001);
    repeat (4) @(posedge ref_clk);
    chk("start interrupt", 32'h1, 32'(irq_seen));
    reg_chk("enable status", pulse_interval_pkg::OFS_ENABLE, 32'h0000_0001);
    // Changing the edge while running must take effect at once
    reg_wr(pulse_interval_pkg::OFS_EDGE, 32'(pulse_interval_pkg::EDGE_RISE));
    partner.drive(1'b0, 6);
    partner.drive(1'b1, 6);
    chk("rise only", 32'h2, 32'(irq_seen));
    reg_wr(pulse_interval_pkg::OFS_STOP, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("enabled after stop", 32'h0, {31'h0, channel_enabled_status});
    reg_rd(pulse_interval_pkg::OFS_COUNT, a);
    reg_rd(pulse_interval_pkg::OFS_DATA, b);
    partner.drive(1'b0, 6);
    partner.drive(1'b1, 6);
    reg_chk("count held", pulse_interval_pkg::OFS_COUNT, a);
    reg_chk("no capture stopped", pulse_interval_pkg::OFS_DATA, b);
    chk("no irq stopped", 32'h2, 32'(irq_seen));
    reg_chk("flag held", pulse_interval_pkg::OFS_STATUS, 32'h0000_0000);
    reg_wr(pulse_interval_pkg::OFS_STATUS_CLR, 32'h0000_0001);
    reg_chk("flag cleared", pulse_interval_pkg::OFS_STATUS, 32'h0000_0000);
  endtask

  // Wrong function or trigger source must not capture
  task automatic t_mode();
    logic [31:0] w [2];
    w[0] = mode_word(2'h0, 2'h0, 1'b0, 4'h0, pulse_interval_pkg::TRIG_EXT_CAPTURE);
    w[1] = mode_word(2'h0, 2'h0, 1'b0, pulse_interval_pkg::FUNC_CAPTURE, 3'h0);
    foreach (w[i])
    begin
      reg_wr(pulse_interval_pkg::OFS_MODE, w[i]);
      irq_seen = 0;
      reg_wr(pulse_interval_pkg::OFS_START, 32'h0000_0001);
      partner.drive(1'b0, 6);
      partner.drive(1'b1, 6);
      chk("no capture irq", 32'h0, 32'(irq_seen));
      reg_wr(pulse_interval_pkg::OFS_STOP, 32'h0000_0001);
    end
  endtask

  task automatic t_output();
    reg_wr(pulse_interval_pkg::OFS_OUTPUT, 32'h0000_0001);
    #1;
    chk("output pin high", 32'h1, {31'h0, timer_output_pin});
    reg_chk("output level", pulse_interval_pkg::OFS_OUTPUT, 32'h0000_0001);
    reg_wr(pulse_interval_pkg::OFS_OUTPUT, 32'h0000_0000);
    #1;
    chk("output pin low", 32'h0, {31'h0, timer_output_pin});
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    err_total = 0;
    checks = 0;
    irq_seen = 0;
    cycles = 0;
    rstn = 1'b0;
    bus_req = '0;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_edges();
    t_stop();
    t_mode();
    t_output();
    test_done();
  end
endmodule

// [verilog/input_edge_sense.sv]
// Timer input synchroniser and valid edge detector sampled on the count tick
`timescale 1ns/1ns
module input_edge_sense
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Sampling
  input wire logic tick,
  input wire logic [1:0] input_edge_select,
  input wire logic pin,
  // Result
  output logic valid_edge
);

  pulse_interval_pkg::edge_state_t s_q;
  pulse_interval_pkg::edge_state_t s_d;
  logic rise;
  logic fall;

  // Only sync2 and the tick-held sample are compared; sync1 feeds sync2 alone
  assign rise = tick && s_q.primed && s_q.sync2 && !s_q.last;
  assign fall = tick && s_q.primed && !s_q.sync2 && s_q.last;

  always_comb
  begin
    s_d = s_q;
    s_d.sync1 = pin;
    s_d.sync2 = s_q.sync1;
    if (tick)
    begin
      s_d.last = s_q.sync2;
      s_d.primed = 1'b1;
    end
  end

  always_comb
  begin
    case (input_edge_select)
      pulse_interval_pkg::EDGE_FALL: valid_edge = fall;
      pulse_interval_pkg::EDGE_RISE: valid_edge = rise;
      default: valid_edge = rise || fall;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

endmodule

// [verilog/pulse_interval_capture.sv]
// One timer channel measuring input pulse intervals in capture mode
`timescale 1ns/1ns
module pulse_interval_capture
#(
  parameter int PRE0_LOG = pulse_interval_pkg::PRE0_LOG,
  parameter int PRE1_LOG = pulse_interval_pkg::PRE1_LOG,
  parameter int PRE2_LOG = pulse_interval_pkg::PRE2_LOG,
  parameter int PRE3_LOG = pulse_interval_pkg::PRE3_LOG
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port
  input wire pulse_interval_pkg::bus_req_t bus_req,
  output logic [pulse_interval_pkg::DATA_W-1:0] rd_data,
  // Timer pins
  input wire logic timer_input_pin,
  output logic timer_output_pin,
  // Status
  output logic channel_interrupt,
  output logic channel_enabled_status
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (PRE0_LOG < 0 || PRE0_LOG >= pulse_interval_pkg::DIV_W ||
      PRE1_LOG < 0 || PRE1_LOG >= pulse_interval_pkg::DIV_W ||
      PRE2_LOG < 0 || PRE2_LOG >= pulse_interval_pkg::DIV_W ||
      PRE3_LOG < 0 || PRE3_LOG >= pulse_interval_pkg::DIV_W)
  begin : g_bad_prescaler
    $error("Prescaler ratio does not fit the divider");
  end

  pulse_interval_pkg::chan_state_t s_q;
  pulse_interval_pkg::chan_state_t s_d;

  // ************************************************************
  // Field views
  // ************************************************************
  logic [1:0] clk_sel;
  logic [1:0] cos;
  logic [2:0] trig_src;
  logic [3:0] func;
  logic start_irq_en;

  assign clk_sel = s_q.mode[pulse_interval_pkg::CLK_SEL_POS +: 2];
  assign cos = s_q.mode[pulse_interval_pkg::COS_POS +: 2];
  assign trig_src = s_q.mode[pulse_interval_pkg::TRIG_SRC_POS +: 3];
  assign func = s_q.mode[pulse_interval_pkg::FUNC_POS +: 4];
  assign start_irq_en = s_q.mode[pulse_interval_pkg::START_IRQ_POS];

  // ************************************************************
  // Prescaler enables
  // ************************************************************
  // Count source and primary select are left to software; only the
  // selected operation clock drives the counter directly.
  logic [3:0] pre_en;
  logic tick;

  function automatic logic div_hit(input logic [pulse_interval_pkg::DIV_W-1:0] div, input int lg);
    logic [pulse_interval_pkg::DIV_W-1:0] mask;
    begin
      mask = (pulse_interval_pkg::DIV_W'(1) << lg) - pulse_interval_pkg::DIV_W'(1);
      div_hit = (div & mask) == '0;
    end
  endfunction

  assign pre_en[0] = div_hit(s_q.div, PRE0_LOG);
  assign pre_en[1] = div_hit(s_q.div, PRE1_LOG);
  assign pre_en[2] = div_hit(s_q.div, PRE2_LOG);
  assign pre_en[3] = div_hit(s_q.div, PRE3_LOG);
  assign tick = pre_en[clk_sel];

  // ************************************************************
  // Edge detection
  // ************************************************************
  logic valid_edge;

  input_edge_sense u_edge
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .tick(tick),
    .input_edge_select(s_q.edge_sel),
    .pin(timer_input_pin),
    .valid_edge(valid_edge)
  );

  // ************************************************************
  // Decoded events
  // ************************************************************
  logic wr_start;
  logic wr_stop;
  logic wr_overflow_clear;
  logic capture_mode;
  logic run_tick;
  logic cap_ev;
  logic wrap_ev;
  logic skip_ev;

  assign wr_start = bus_req.wr && bus_req.addr == pulse_interval_pkg::OFS_START &&
                    bus_req.wdata[pulse_interval_pkg::TRIG_POS];
  assign wr_stop = bus_req.wr && bus_req.addr == pulse_interval_pkg::OFS_STOP &&
                   bus_req.wdata[pulse_interval_pkg::TRIG_POS];
  assign wr_overflow_clear = bus_req.wr && bus_req.addr == pulse_interval_pkg::OFS_STATUS_CLR &&
                   bus_req.wdata[pulse_interval_pkg::FLAG_CLR_POS];
  assign capture_mode = func == pulse_interval_pkg::FUNC_CAPTURE &&
                        trig_src == pulse_interval_pkg::TRIG_EXT_CAPTURE;
  // A start in the same cycle takes over the counter
  assign run_tick = s_q.enabled && tick && !wr_start;
  // Fill modes swallow the first edge after a wrap
  assign skip_ev = run_tick && capture_mode && valid_edge && s_q.wrapped && cos[1];
  assign cap_ev = run_tick && capture_mode && valid_edge && !skip_ev;
  assign wrap_ev = run_tick && !(capture_mode && valid_edge) &&
                   s_q.count == pulse_interval_pkg::CNT_MAX;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    s_d = s_q;
    s_d.div = s_q.div + pulse_interval_pkg::DIV_W'(1);
    s_d.irq = 1'b0;

    if (bus_req.wr)
    begin
      case (bus_req.addr)
        pulse_interval_pkg::OFS_MODE:
          s_d.mode = bus_req.wdata[pulse_interval_pkg::MODE_W-1:0];
        pulse_interval_pkg::OFS_EDGE:
          s_d.edge_sel = bus_req.wdata[1:0];
        pulse_interval_pkg::OFS_DATA:
          s_d.cap_data = bus_req.wdata[pulse_interval_pkg::CNT_W-1:0];
        pulse_interval_pkg::OFS_REWRITE:
          s_d.rewrite = bus_req.wdata[1:0];
        pulse_interval_pkg::OFS_OUTPUT:
          s_d.out_level = bus_req.wdata[0];
        default:
        begin
        end
      endcase
    end

    // Only this clear lowers the flag; later sets override it
    if (wr_overflow_clear)
      s_d.ovf = 1'b0;

    if (wr_stop)
      s_d.enabled = 1'b0;

    if (wr_start)
    begin
      s_d.enabled = 1'b1;
      s_d.count = pulse_interval_pkg::CNT_ZERO;
      s_d.wrapped = 1'b0;
      s_d.irq = start_irq_en;
    end
    else if (skip_ev)
    begin
      s_d.count = pulse_interval_pkg::CNT_ZERO;
      s_d.wrapped = 1'b0;
      s_d.irq = cos == pulse_interval_pkg::COS_FILL_FLAG;
    end
    else if (cap_ev)
    begin
      s_d.cap_data = s_q.count;
      s_d.count = pulse_interval_pkg::CNT_ZERO;
      s_d.wrapped = 1'b0;
      s_d.irq = 1'b1;
      if (s_q.wrapped && cos == pulse_interval_pkg::COS_KEEP)
        s_d.ovf = 1'b1;
    end
    else if (wrap_ev)
    begin
      s_d.count = pulse_interval_pkg::CNT_ZERO;
      s_d.wrapped = 1'b1;
      if (cos[0])
        s_d.ovf = 1'b1;
      if (cos[1])
        s_d.cap_data = pulse_interval_pkg::CNT_MAX;
    end
    else if (run_tick)
      s_d.count = s_q.count + pulse_interval_pkg::CNT_W'(1);

    // Reads never touch measurement state
    s_d.rdata = '0;
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        pulse_interval_pkg::OFS_MODE:
          s_d.rdata = {16'h0000, s_q.mode};
        pulse_interval_pkg::OFS_EDGE:
          s_d.rdata = {30'h0000_0000, s_q.edge_sel};
        pulse_interval_pkg::OFS_DATA:
          s_d.rdata = s_q.cap_data;
        pulse_interval_pkg::OFS_COUNT:
          s_d.rdata = s_q.count;
        pulse_interval_pkg::OFS_STATUS:
          s_d.rdata = {31'h0000_0000, s_q.ovf};
        pulse_interval_pkg::OFS_ENABLE:
          s_d.rdata = {31'h0000_0000, s_q.enabled};
        pulse_interval_pkg::OFS_REWRITE:
          s_d.rdata = {30'h0000_0000, s_q.rewrite};
        pulse_interval_pkg::OFS_OUTPUT:
          s_d.rdata = {31'h0000_0000, s_q.out_level};
        default:
          s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
      s_q.mode <= pulse_interval_pkg::MODE_RST;
      s_q.edge_sel <= pulse_interval_pkg::EDGE_RST;
      s_q.cap_data <= pulse_interval_pkg::DATA_RST;
    end
    else
      s_q <= s_d;
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign rd_data = s_q.rdata;
  assign channel_interrupt = s_q.irq;
  assign channel_enabled_status = s_q.enabled;
  assign timer_output_pin = s_q.out_level;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  a_start_zeroes_count:
    assert property (wr_start |=> s_q.count == pulse_interval_pkg::CNT_ZERO && s_q.enabled)
    else $error("start did not zero counter and enable channel");

  a_start_irq_gate:
    assert property (wr_start |=> channel_interrupt == $past(start_irq_en))
    else $error("start interrupt does not follow its enable bit");

  a_stop_holds_count:
    assert property (wr_stop && !wr_start |=> !s_q.enabled ##1 ($stable(s_q.count) ||
                     $past(wr_start)))
    else $error("stop did not halt counter");

  a_capture_copies:
    assert property (cap_ev |=> s_q.cap_data == $past(s_q.count) &&
                     s_q.count == pulse_interval_pkg::CNT_ZERO && channel_interrupt)
    else $error("capture did not copy count and interrupt");

  a_wrap_to_zero:
    assert property (wrap_ev |=> s_q.count == pulse_interval_pkg::CNT_ZERO && s_q.enabled)
    else $error("counter did not wrap to zero");

  a_fill_on_wrap:
    assert property (wrap_ev && cos[1] && !bus_req.wr |=> s_q.cap_data == pulse_interval_pkg::CNT_MAX)
    else $error("fill mode did not load all ones");

  a_flag_at_capture:
    assert property (cap_ev && s_q.wrapped && cos == pulse_interval_pkg::COS_KEEP |=> s_q.ovf)
    else $error("overflow flag not set on capture after wrap");

  a_flag_sticky:
    assert property (s_q.ovf && !wr_overflow_clear |=> s_q.ovf)
    else $error("overflow flag dropped without clear");

  a_flag_clear:
    assert property (wr_overflow_clear && !wrap_ev && !cap_ev |=> !s_q.ovf)
    else $error("overflow clear ignored");

  a_skip_no_capture:
    assert property (skip_ev && !bus_req.wr |=> $stable(s_q.cap_data) &&
                     channel_interrupt == (cos == pulse_interval_pkg::COS_FILL_FLAG))
    else $error("edge after wrap in fill mode handled wrongly");

endmodule

// [verilog/pulse_interval_pkg.sv]
// Constants, register map and carrier types of the pulse interval capture channel
package pulse_interval_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int CNT_W = 32;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DIV_W = 16;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EDGE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DATA = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS_CLR = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_START = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_STOP = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_REWRITE = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT = 8'h28;

  // ************************************************************
  // Field positions and codes
  // ************************************************************
  localparam int MODE_W = 16;
  localparam int CLK_SEL_POS = 14;
  localparam int CNT_SRC_POS = 12;
  localparam int PRIMARY_SEL_POS = 11;
  localparam int TRIG_SRC_POS = 8;
  localparam int COS_POS = 6;
  localparam int FUNC_POS = 1;
  localparam int START_IRQ_POS = 0;
  localparam int FLAG_POS = 0;
  localparam int FLAG_CLR_POS = 0;
  localparam int TRIG_POS = 0;
  localparam logic [2:0] TRIG_EXT_CAPTURE = 3'h1;
  localparam logic [3:0] FUNC_CAPTURE = 4'h2;
  localparam logic [1:0] COS_KEEP = 2'h0;
  localparam logic [1:0] COS_FLAG = 2'h1;
  localparam logic [1:0] COS_FILL = 2'h2;
  localparam logic [1:0] COS_FILL_FLAG = 2'h3;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;

  // ************************************************************
  // Reset values and counter limits
  // ************************************************************
  localparam logic [MODE_W-1:0] MODE_RST = 16'h0000;
  localparam logic [1:0] EDGE_RST = 2'h0;
  localparam logic [CNT_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 32'hFFFF_FFFF;

  // ************************************************************
  // Prescaler defaults, log2 of each division ratio
  // ************************************************************
  localparam int PRE0_LOG = 0;
  localparam int PRE1_LOG = 1;
  localparam int PRE2_LOG = 2;
  localparam int PRE3_LOG = 4;

  // ************************************************************
  // Carriers and state
  // ************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic last;
    logic primed;
  } edge_state_t;

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [MODE_W-1:0] mode;
    logic [1:0] edge_sel;
    logic [1:0] rewrite;
    logic out_level;
    logic [CNT_W-1:0] cap_data;
    logic [CNT_W-1:0] count;
    logic ovf;
    logic enabled;
    logic wrapped;
    logic irq;
    logic [DATA_W-1:0] rdata;
  } chan_state_t;

endpackage
